// ### hw/rxdc_pkg.sv
// constants for the receive dma channel state and free-reference cache
`default_nettype none
package rxdc_pkg;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BUF_SIZE = 8'h04;
    localparam logic [7:0] REG_HEAD_OFF = 8'h08;
    localparam logic [7:0] REG_QUEUE_BASE = 8'h0c;
    localparam logic [7:0] REG_BUF_BASE = 8'h10;
    localparam logic [7:0] REG_SFQ_BOUNDS = 8'h14;
    localparam logic [7:0] REG_SFQ_INDEX = 8'h18;
    localparam logic [7:0] REG_LFQ_BOUNDS = 8'h1c;
    localparam logic [7:0] REG_LFQ_INDEX = 8'h20;
    localparam logic [7:0] REG_RQ_BOUNDS = 8'h24;
    localparam logic [7:0] REG_RQ_INDEX = 8'h28;
    localparam logic [7:0] REG_STATUS = 8'h2c;
    localparam logic [7:0] REG_VALID = 8'h30;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int CTRL_LIMIT_LSB = 0;
    localparam int CTRL_RAW_BIT = 2;
    localparam int CTRL_EN_BIT = 3;
    localparam int STATUS_EXH_BIT = 0;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [31:0] BUF_SIZE_RESET = 32'h0800_0100;
    // ****************************************
    // queue entries and buffers
    // ****************************************
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_FAIL = 2'h1;
    localparam logic [1:0] ST_PARTIAL = 2'h2;
    localparam logic [3:0] RQ_BYTE_EN = 4'h7;
    localparam int BUF_SHIFT = 16;
    localparam int REF_W = 14;
    localparam int KIND_SMALL = 0;
    localparam int KIND_LARGE = 1;
    localparam int DEF_NUM_CHAN = 32;
    localparam int DEF_CACHE_DEPTH = 6;
endpackage
`default_nettype wire

// ### hw/rxdc_top.sv
// receive dma channel state table, write pipeline and free-reference caches
//
// Operation
// - thirty-two channels, three context words each
// - new buffer: remaining count is size less head offset
// - remaining count drops by one per byte
// - raw count starts from control raw limit
// - raw count drops per full buffer; at zero post chain
// - entry holds current and first descriptor references
// - entry holds size of current buffer
// - valid flag: packet in progress, fields meaningful
// - entry holds host address, advanced per access
// - interleaved packet pieces, context restored
// - own host transfers for queues
// - receive data piped until control is ready
// - output data muxed: piped data or own transfers
// - two six-entry free caches, small and large
// - caches independent, consumed singly
// - refill only when empty and needed
// - refill fetches at most six, fewer when short
// - refill stops at queue end; one transfer each
// - queue empty when read one below write, or wrapped
// - substitute other queue; both empty raises flag
// - ready entry: status over reference, third byte zero
// - remover updates read index, adder write index
//
// Strobed register access and the address map are this design's own decisions.
`default_nettype none
module rxdc_top import rxdc_pkg::*; #(
    parameter int NUM_CHAN = DEF_NUM_CHAN,
    parameter int CACHE_DEPTH = DEF_CACHE_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // receive bytes from the hdlc processor
    input wire logic rx_valid,
    input wire logic [$clog2(NUM_CHAN)-1:0] rx_chan,
    input wire logic [7:0] rx_byte,
    input wire logic rx_eop,
    input wire logic rx_err,
    output logic rx_ready,
    // host bus controller request and read return
    output logic hb_req,
    output logic hb_we,
    output logic [31:0] hb_addr,
    output logic [31:0] hb_wdata,
    output logic [3:0] hb_be,
    output logic [2:0] hb_len,
    input wire logic hb_ready,
    input wire logic hb_rvalid,
    input wire logic [31:0] hb_rdata,
    // error flag
    output logic free_queue_exhausted_irq
);
    localparam int CHW = $clog2(NUM_CHAN);

    if (NUM_CHAN < 2 || NUM_CHAN > 32 || CACHE_DEPTH < 1 || CACHE_DEPTH > 7) begin : g_chk
        $error("rxdc_top: unsupported channel count or cache depth");
    end

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CTX = 3'h1,
        S_GET = 3'h2,
        S_FILL = 3'h3,
        S_FWAIT = 3'h4,
        S_WR = 3'h5,
        S_POST = 3'h6
    } rxdc_state_t;

    // ****************************************
    // state
    // ****************************************
    rxdc_state_t st_q;
    logic [3:0] ctrl_q;
    logic [31:0] size_cfg_q, qbase_q, bbase_q;
    logic [15:0] head_off_q;
    logic [15:0] fq_start_q [2], fq_end_q [2], fq_wr_q [2], fq_rd_q [2];
    logic [15:0] rq_start_q, rq_end_q, rq_wr_q, rq_rd_q;
    logic [NUM_CHAN-1:0] v_q;
    logic [15:0] avail_q [NUM_CHAN];
    logic [1:0] rbc_q [NUM_CHAN];
    logic [REF_W-1:0] ref_q [NUM_CHAN];
    logic [15:0] bsize_q [NUM_CHAN];
    logic [REF_W-1:0] sref_q [NUM_CHAN];
    logic [31:0] addr_q [NUM_CHAN];
    logic [REF_W-1:0] cache_q [2][CACHE_DEPTH];
    logic [2:0] ccnt_q [2], chead_q [2];
    logic [CHW-1:0] ch_q;
    logic [7:0] pipe_byte_q;
    logic pipe_eop_q, pipe_err_q;
    logic post_q;
    logic [1:0] post_st_q;
    logic fk_q;
    logic [2:0] fill_n_q, fill_i_q;
    logic rx_ready_q, req_q, we_q, irq_q;
    logic [31:0] haddr_q, hwdata_q, rdata_q;
    logic [3:0] be_q;
    logic [2:0] len_q;

    // ****************************************
    // decode
    // ****************************************
    logic cur_v, want, other, accept, taken;
    logic [15:0] cur_avail, avail_dec;
    logic [31:0] cur_addr;
    logic [1:0] cur_rbc;
    logic c_has [2], q_empty [2];
    logic [15:0] nxt [2], span [2];
    logic [2:0] fetch_n [2];
    logic pop_en, fill_en, exhausted, pop_k, fill_k;
    logic [REF_W-1:0] pop_ref;
    logic [15:0] pop_size, rq_next;
    logic raw_full, raw_last;
    logic [31:0] rd_mux;
    logic [15:0] end_m1;

    // context of the channel in hand is looked up again on every visit
    assign cur_v = v_q[ch_q];
    assign cur_avail = avail_q[ch_q];
    assign cur_addr = addr_q[ch_q];
    assign cur_rbc = rbc_q[ch_q];
    assign avail_dec = cur_avail - 16'h0001;
    assign want = cur_v; // first buffer of a packet is small, later ones large
    assign other = ~cur_v;
    assign accept = rx_valid && rx_ready_q;
    assign taken = req_q && hb_ready;
    assign end_m1 = reg_wdata[31:16] - 16'h0001;

    // per-queue empty test and refill length; one generate over both kinds
    for (genvar k = 0; k < 2; k++) begin : g_fq
        assign c_has[k] = ccnt_q[k] != 3'h0;
        assign q_empty[k] = (fq_rd_q[k] + 16'h0001 == fq_wr_q[k]) ||
            (fq_rd_q[k] + 16'h0001 == fq_end_q[k] && fq_wr_q[k] == fq_start_q[k]);
        assign nxt[k] = (fq_rd_q[k] + 16'h0001 == fq_end_q[k]) ? fq_start_q[k] :
            fq_rd_q[k] + 16'h0001;
        // stopping at the end keeps each refill one host transfer
        assign span[k] = (fq_wr_q[k] >= nxt[k]) ? fq_wr_q[k] - nxt[k] :
            fq_end_q[k] - nxt[k];
        assign fetch_n[k] = (span[k] >= 16'(CACHE_DEPTH)) ? 3'(CACHE_DEPTH) :
            span[k][2:0];
    end

    // buffer source: own cache, other cache, own queue, other queue
    assign pop_en = c_has[want] || c_has[other];
    assign pop_k = c_has[want] ? want : other;
    assign fill_en = !pop_en && (!q_empty[want] || !q_empty[other]);
    assign fill_k = !q_empty[want] ? want : other;
    assign exhausted = !pop_en && !fill_en;
    assign pop_ref = cache_q[pop_k][chead_q[pop_k]];
    assign pop_size = pop_k ? size_cfg_q[31:16] : size_cfg_q[15:0];
    assign raw_full = ctrl_q[CTRL_RAW_BIT] && avail_dec == 16'h0000;
    assign raw_last = cur_rbc <= 2'h1;
    assign rq_next = (rq_wr_q + 16'h0001 == rq_end_q) ? rq_start_q : rq_wr_q + 16'h0001;

    // ****************************************
    // register read mux
    // ****************************************
    always_comb begin
        unique case (reg_addr)
            REG_CTRL: rd_mux = {28'h0, ctrl_q};
            REG_BUF_SIZE: rd_mux = size_cfg_q;
            REG_HEAD_OFF: rd_mux = {16'h0, head_off_q};
            REG_QUEUE_BASE: rd_mux = qbase_q;
            REG_BUF_BASE: rd_mux = bbase_q;
            REG_SFQ_BOUNDS: rd_mux = {fq_end_q[KIND_SMALL], fq_start_q[KIND_SMALL]};
            REG_SFQ_INDEX: rd_mux = {fq_rd_q[KIND_SMALL], fq_wr_q[KIND_SMALL]};
            REG_LFQ_BOUNDS: rd_mux = {fq_end_q[KIND_LARGE], fq_start_q[KIND_LARGE]};
            REG_LFQ_INDEX: rd_mux = {fq_rd_q[KIND_LARGE], fq_wr_q[KIND_LARGE]};
            REG_RQ_BOUNDS: rd_mux = {rq_end_q, rq_start_q};
            REG_RQ_INDEX: rd_mux = {rq_rd_q, rq_wr_q};
            REG_STATUS: rd_mux = {25'h0, ccnt_q[KIND_LARGE], ccnt_q[KIND_SMALL], irq_q};
            REG_VALID: rd_mux = 32'(v_q);
            default: rd_mux = 32'h0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ****************************************
    // host-owned configuration and indices
    // ****************************************
    // the host writes only the indices it owns: free write, ready read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RESET;
            size_cfg_q <= BUF_SIZE_RESET;
            head_off_q <= 16'h0;
            qbase_q <= 32'h0;
            bbase_q <= 32'h0;
            fq_start_q <= '{default: 16'h0};
            fq_end_q <= '{default: 16'h0};
            fq_wr_q <= '{default: 16'h0};
            rq_start_q <= 16'h0;
            rq_end_q <= 16'h0;
            rq_rd_q <= 16'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL: ctrl_q <= reg_wdata[3:0];
                REG_BUF_SIZE: size_cfg_q <= reg_wdata;
                REG_HEAD_OFF: head_off_q <= reg_wdata[15:0];
                REG_QUEUE_BASE: qbase_q <= {reg_wdata[31:2], 2'h0};
                REG_BUF_BASE: bbase_q <= reg_wdata;
                REG_SFQ_BOUNDS: {fq_end_q[KIND_SMALL], fq_start_q[KIND_SMALL]} <= reg_wdata;
                REG_SFQ_INDEX: fq_wr_q[KIND_SMALL] <= reg_wdata[15:0];
                REG_LFQ_BOUNDS: {fq_end_q[KIND_LARGE], fq_start_q[KIND_LARGE]} <= reg_wdata;
                REG_LFQ_INDEX: fq_wr_q[KIND_LARGE] <= reg_wdata[15:0];
                REG_RQ_BOUNDS: {rq_end_q, rq_start_q} <= reg_wdata;
                REG_RQ_INDEX: rq_rd_q <= reg_wdata[31:16];
                default: ;
            endcase
        end
    end

    // ****************************************
    // channel context table
    // ****************************************
    // data fields carry no reset; the valid flag guards them
    always_ff @(posedge clk) begin
        if (st_q == S_GET && pop_en) begin
            ref_q[ch_q] <= pop_ref;
            bsize_q[ch_q] <= pop_size;
            avail_q[ch_q] <= pop_size - head_off_q;
            addr_q[ch_q] <= bbase_q + (32'(pop_ref) << BUF_SHIFT) + 32'(head_off_q);
            if (!cur_v) begin
                sref_q[ch_q] <= pop_ref;
                rbc_q[ch_q] <= ctrl_q[CTRL_LIMIT_LSB +: 2];
            end
        end else if (st_q == S_WR && !req_q) begin
            avail_q[ch_q] <= avail_dec;
            addr_q[ch_q] <= cur_addr + 32'h1;
            if (raw_full && !raw_last) begin
                rbc_q[ch_q] <= cur_rbc - 2'h1;
            end
        end
    end

    // valid flags, cleared at reset so every channel starts afresh
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            v_q <= '0;
        end else if (st_q == S_GET && pop_en) begin
            v_q[ch_q] <= 1'b1;
        end else if (st_q == S_POST && taken) begin
            v_q[ch_q] <= 1'b0;
        end
    end

    // ****************************************
    // free-reference caches
    // ****************************************
    always_ff @(posedge clk) begin
        if (st_q == S_FWAIT && hb_rvalid) begin
            cache_q[fk_q][fill_i_q] <= hb_rdata[REF_W-1:0];
        end
    end

    // ****************************************
    // transaction controller
    // ****************************************
    // one process owns every hardware-written index and the bus request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= S_IDLE;
            ccnt_q <= '{default: 3'h0};
            chead_q <= '{default: 3'h0};
            fq_rd_q <= '{default: 16'h0};
            rq_wr_q <= 16'h0;
            ch_q <= '0;
            pipe_byte_q <= 8'h0;
            pipe_eop_q <= 1'b0;
            pipe_err_q <= 1'b0;
            post_q <= 1'b0;
            post_st_q <= ST_OK;
            fk_q <= 1'b0;
            fill_n_q <= 3'h0;
            fill_i_q <= 3'h0;
            rx_ready_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            haddr_q <= 32'h0;
            hwdata_q <= 32'h0;
            be_q <= 4'h0;
            len_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            // the error flag clears by writing one; a new event wins
            if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STATUS_EXH_BIT]) begin
                irq_q <= 1'b0;
            end
            // bounds writes reset the hardware index: free read to end less one, ready write to start
            if (reg_wr && reg_addr == REG_SFQ_BOUNDS) fq_rd_q[KIND_SMALL] <= end_m1;
            if (reg_wr && reg_addr == REG_LFQ_BOUNDS) fq_rd_q[KIND_LARGE] <= end_m1;
            if (reg_wr && reg_addr == REG_RQ_BOUNDS) rq_wr_q <= reg_wdata[15:0];
            unique case (st_q)
                S_IDLE: begin
                    rx_ready_q <= ctrl_q[CTRL_EN_BIT] && !accept;
                    if (accept) begin
                        // byte waits here while control is worked out
                        ch_q <= rx_chan;
                        pipe_byte_q <= rx_byte;
                        pipe_eop_q <= rx_eop;
                        pipe_err_q <= rx_err;
                        st_q <= S_CTX;
                    end
                end
                S_CTX: begin
                    st_q <= (!cur_v || cur_avail == 16'h0) ? S_GET : S_WR;
                end
                S_GET: begin
                    if (pop_en) begin
                        ccnt_q[pop_k] <= ccnt_q[pop_k] - 3'h1;
                        chead_q[pop_k] <= chead_q[pop_k] + 3'h1;
                        st_q <= S_WR;
                    end else if (fill_en) begin
                        fk_q <= fill_k;
                        fill_n_q <= fetch_n[fill_k];
                        fill_i_q <= 3'h0;
                        req_q <= 1'b1;
                        we_q <= 1'b0;
                        haddr_q <= qbase_q + {14'h0, nxt[fill_k], 2'h0};
                        be_q <= 4'hf;
                        len_q <= fetch_n[fill_k];
                        st_q <= S_FILL;
                    end else begin
                        irq_q <= 1'b1;
                        // a packet cut short goes out as partial; the byte is lost
                        post_st_q <= ST_PARTIAL;
                        st_q <= cur_v ? S_POST : S_IDLE;
                    end
                end
                S_FILL: begin
                    if (taken) begin
                        req_q <= 1'b0;
                        st_q <= S_FWAIT;
                    end
                end
                S_FWAIT: begin
                    if (hb_rvalid) begin
                        fill_i_q <= fill_i_q + 3'h1;
                        if (fill_i_q == fill_n_q - 3'h1) begin
                            ccnt_q[fk_q] <= fill_n_q;
                            chead_q[fk_q] <= 3'h0;
                            fq_rd_q[fk_q] <= nxt[fk_q] + 16'(fill_n_q) - 16'h1;
                            st_q <= S_GET;
                        end
                    end
                end
                S_WR: begin
                    if (!req_q) begin
                        // pipelined byte goes out on its own lane
                        req_q <= 1'b1;
                        we_q <= 1'b1;
                        haddr_q <= cur_addr;
                        hwdata_q <= {4{pipe_byte_q}};
                        be_q <= 4'h1 << cur_addr[1:0];
                        len_q <= 3'h1;
                        post_q <= pipe_eop_q || (raw_full && raw_last);
                        post_st_q <= (pipe_eop_q && pipe_err_q) ? ST_FAIL : ST_OK;
                    end else if (taken) begin
                        req_q <= 1'b0;
                        st_q <= post_q ? S_POST : S_IDLE;
                    end
                end
                S_POST: begin
                    if (!req_q) begin
                        req_q <= 1'b1;
                        we_q <= 1'b1;
                        haddr_q <= qbase_q + {14'h0, rq_wr_q, 2'h0};
                        hwdata_q <= {8'h00, 8'h00, post_st_q, sref_q[ch_q]};
                        be_q <= RQ_BYTE_EN;
                        len_q <= 3'h1;
                    end else if (taken) begin
                        req_q <= 1'b0;
                        rq_wr_q <= rq_next;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = rdata_q;
    assign rx_ready = rx_ready_q;
    assign hb_req = req_q;
    assign hb_we = we_q;
    assign hb_addr = haddr_q;
    assign hb_wdata = hwdata_q;
    assign hb_be = be_q;
    assign hb_len = len_q;
    assign free_queue_exhausted_irq = irq_q;
endmodule
`default_nettype wire

// ### sim/rxdc_monitor.sv
// port checker for the receive dma block, bound to its top
`default_nettype none
module rxdc_monitor import rxdc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // receive stream and host bus
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic hb_req,
    input wire logic hb_we,
    input wire logic [31:0] hb_addr,
    input wire logic [31:0] hb_wdata,
    input wire logic [3:0] hb_be,
    input wire logic [2:0] hb_len,
    input wire logic hb_ready,
    input wire logic free_queue_exhausted_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ****
    // decodes
    // ****
    wire logic post_w = hb_req && hb_we && hb_be == RQ_BYTE_EN;
    wire logic byte_w = hb_req && hb_we && hb_be != RQ_BYTE_EN;
    wire logic clr_w = reg_wr && reg_addr == REG_STATUS && reg_wdata[STATUS_EXH_BIT];
    // read data shows only in the cycle after a read strobe
    property p_rd_quiet;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
    // a request stands unchanged until taken, then drops
    property p_hold;
        hb_req && !hb_ready |=> hb_req && $stable(hb_addr) && $stable(hb_wdata) && $stable(hb_len);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed while waiting");
    property p_one;
        hb_req && hb_ready |=> !hb_req;
    endproperty
    a_one: assert property (p_one) else $error("request kept after take");
    // a taken byte blocks the stream while context is restored
    property p_rx_drop;
        rx_valid && rx_ready |=> !rx_ready [*2];
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("stream ready too early");
    property p_lane;
        byte_w |-> hb_be == (4'h1 << hb_addr[1:0]) && hb_len == 3'h1;
    endproperty
    a_lane: assert property (p_lane) else $error("byte lane mismatch");
    property p_rep;
        byte_w |-> hb_wdata == {4{hb_wdata[7:0]}};
    endproperty
    a_rep: assert property (p_rep) else $error("byte not replicated");
    property p_post;
        post_w |-> hb_wdata[23:16] == 8'h0 && hb_wdata[15:14] != 2'h3 && hb_len == 3'h1;
    endproperty
    a_post: assert property (p_post) else $error("bad ready entry");
    property p_rlen;
        hb_req && !hb_we |-> hb_len inside {[3'h1:3'h6]};
    endproperty
    a_rlen: assert property (p_rlen) else $error("refill length out of range");
    // the exhausted flag is sticky until software clears it
    property p_sticky;
        free_queue_exhausted_irq && !clr_w |=> free_queue_exhausted_irq;
    endproperty
    a_sticky: assert property (p_sticky) else $error("exhausted flag dropped");
    c_byte: cover property (byte_w && hb_ready);
    c_refill: cover property (hb_req && !hb_we && hb_ready);
    c_post: cover property (post_w && hb_ready);
endmodule
bind rxdc_top rxdc_monitor rxdc_monitor_inst (.*);
`default_nettype wire

// ### sim/rxdc_host_model.sv
// host bus controller model over a small dword memory
`default_nettype none
module rxdc_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request from the dma block
    input wire logic hb_req,
    input wire logic hb_we,
    input wire logic [31:0] hb_addr,
    input wire logic [31:0] hb_wdata,
    input wire logic [3:0] hb_be,
    input wire logic [2:0] hb_len,
    // answer
    output logic hb_ready,
    output logic hb_rvalid,
    output logic [31:0] hb_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255];
    logic [31:0] last_wa, last_wd, last_ra;
    logic [3:0] last_wbe;
    logic [2:0] last_rl, nret;
    logic [7:0] ptr;
    logic [1:0] cnt;
    logic slow;
    // each word holds its own index as reference, top byte marked
    initial for (int i = 0; i < 256; i++) mem[i] = 32'haa00_0000 | i;
    // answers alternate prompt and slow so both timings are seen
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hb_ready <= 1'b0;
            hb_rvalid <= 1'b0;
            hb_rdata <= 32'h0;
            nret <= 3'h0;
            cnt <= 2'h0;
            slow <= 1'b0;
        end else begin
            hb_ready <= 1'b0;
            hb_rvalid <= 1'b0;
            hb_rdata <= ~hb_rdata; // idle bus inverts the last data each cycle, so stale data shows on alternate cycles
            if (nret != 3'h0) begin
                hb_rvalid <= 1'b1;
                hb_rdata <= mem[ptr];
                ptr <= ptr + 8'h1;
                nret <= nret - 3'h1;
            end else if (hb_req && hb_ready) begin
                slow <= !slow;
                if (hb_we) begin
                    last_wa <= hb_addr;
                    last_wd <= hb_wdata;
                    last_wbe <= hb_be;
                    for (int i = 0; i < 4; i++)
                        if (hb_be[i]) mem[hb_addr[9:2]][8*i +: 8] <= hb_wdata[8*i +: 8];
                end else begin
                    last_ra <= hb_addr;
                    last_rl <= hb_len;
                    ptr <= hb_addr[9:2];
                    nret <= hb_len;
                end
            end else if (hb_req) begin
                cnt <= cnt + 2'h1;
                if (!slow || cnt == 2'h3) begin
                    hb_ready <= 1'b1;
                    cnt <= 2'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the receive dma channel state and free cache
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench import rxdc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BB = 32'h1000_0000;
    logic clk, arst_n, reg_wr, reg_rd, rx_valid, rx_eop, rx_err, rx_ready;
    logic hb_req, hb_we, hb_ready, hb_rvalid, free_queue_exhausted_irq;
    logic [7:0] reg_addr, rx_byte, f, n;
    logic [4:0] rx_chan;
    logic [31:0] reg_wdata, reg_rdata, hb_addr, hb_wdata, hb_rdata, d, a;
    logic [3:0] hb_be;
    logic [2:0] hb_len;
    int err_count = 0;
    int compares = 0;
    rxdc_top rxdc_top_inst (.*);
    rxdc_host_model host_inst (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ****
    // access tasks
    // ****
    task final_report();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] ad, output logic [31:0] rdv);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    // bounded wait for the stream to come back to idle
    task automatic idle();
        int i;
        for (i = 0; i < 400 && rx_ready !== 1'b1; i++) @(negedge clk);
        if (i == 400) begin
            err_count++;
            final_report();
        end
    endtask
    task send(input logic [4:0] ch, input logic [7:0] b, input logic e, input logic x);
        idle();
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_chan <= ch;
        rx_byte <= b;
        rx_eop <= e;
        rx_err <= x;
        @(posedge clk);
        rx_valid <= 1'b0;
        repeat (2) @(negedge clk);
        idle();
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {arst_n, reg_wr, reg_rd, rx_valid, rx_eop, rx_err} = 6'h0;
        {reg_addr, rx_byte, rx_chan, reg_wdata} = 53'h0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rd(REG_CTRL, d); `CHK("ctrl", {28'h0, CTRL_RESET}, d)
        rd(REG_BUF_SIZE, d); `CHK("size", BUF_SIZE_RESET, d)
        rd(REG_VALID, d); `CHK("valid", 32'h0, d)
        rd(REG_STATUS, d); `CHK("caches", 32'h0, d)
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc, d); `CHK("unmapped", 32'h0, d)
        $display("reset test done");
        wr(REG_HEAD_OFF, 32'h2);
        wr(REG_QUEUE_BASE, 32'h0);
        wr(REG_BUF_BASE, BB);
        wr(REG_SFQ_BOUNDS, 32'h0018_0010);
        wr(REG_SFQ_INDEX, 32'h0000_0017);
        wr(REG_LFQ_BOUNDS, 32'h0030_0020);
        wr(REG_LFQ_INDEX, 32'h0000_0027);
        wr(REG_RQ_BOUNDS, 32'h0048_0040);
        wr(REG_RQ_INDEX, 32'h0047_0000);
        wr(REG_CTRL, 32'h8);
        send(5'd3, 8'h5a, 1'b0, 1'b0);
        f = host_inst.last_ra[9:2];
        n = (8'h17 - f > 8'h6) ? 8'h6 : 8'h17 - f;
        `CHK("refill start", 1'b1, f >= 8'h10 && f < 8'h17)
        `CHK("refill len", n, {5'h0, host_inst.last_rl})
        `CHK("byte addr", BB + {8'h0, f, 16'h2}, host_inst.last_wa)
        `CHK("byte data", 32'h5a5a_5a5a, host_inst.last_wd)
        `CHK("byte lane", 4'h4, host_inst.last_wbe)
        $display("first byte test done");
        send(5'd5, 8'h33, 1'b0, 1'b0);
        `CHK("ch5 addr", BB + {8'h0, f + 8'h1, 16'h2}, host_inst.last_wa)
        send(5'd3, 8'h11, 1'b0, 1'b0);
        `CHK("ch3 addr", BB + {8'h0, f, 16'h3}, host_inst.last_wa)
        `CHK("ch3 lane", 4'h8, host_inst.last_wbe)
        rd(REG_VALID, d); `CHK("valid", 32'h28, d)
        rd(REG_STATUS, d); `CHK("small count", n - 8'h2, {5'h0, d[3:1]})
        $display("interleave test done");
        send(5'd3, 8'h22, 1'b1, 1'b0);
        a = host_inst.last_wa;
        `CHK("post ok", {16'h0, ST_OK, 6'h0, f}, host_inst.last_wd)
        `CHK("post be", RQ_BYTE_EN, host_inst.last_wbe)
        `CHK("top byte", 8'haa, host_inst.mem[a[9:2]][31:24])
        `CHK("post slot", 1'b1, a[9:2] >= 8'h40 && a[9:2] < 8'h48)
        send(5'd5, 8'h44, 1'b1, 1'b1);
        `CHK("post fail", {16'h0, ST_FAIL, 6'h0, f + 8'h1}, host_inst.last_wd)
        `CHK("post next", a + 32'h4, host_inst.last_wa)
        rd(REG_VALID, d); `CHK("valid end", 32'h0, d)
        `CHK("no exhaust", 1'b0, free_queue_exhausted_irq)
        $display("post test done");
        final_report();
    end
endmodule
`default_nettype wire
